// ===== verilog/dacfr_consts.svh
// dacfr_consts.svh: offsets, field positions, reset values and cycle counts of the
// dual channel converter front end. assumes inclusion by bare name, definitions only.
`ifndef DACFR_CONSTS_SVH
`define DACFR_CONSTS_SVH

// apb register byte offsets
`define DACFR_ADDR_W          8
`define DACFR_OFS_CTRL        8'h00
`define DACFR_OFS_SOFTWARE_TRIGGER_BIT      8'h04
`define DACFR_OFS_SINGLE_BASE 8'h08
`define DACFR_SINGLE_STRIDE   8'h0c
`define DACFR_OFS_8R          8'h00
`define DACFR_OFS_12L         8'h04
`define DACFR_OFS_12R         8'h08
`define DACFR_OFS_D12R        8'h20
`define DACFR_OFS_D12L        8'h24
`define DACFR_OFS_D8R         8'h28
`define DACFR_OFS_OUT1        8'h2c
`define DACFR_OFS_OUT2        8'h30

// field positions
`define DACFR_CH_STRIDE       16
`define DACFR_CH_FIELD_W      13
`define DACFR_D8_CH2_LSB      8
`define DACFR_12L_LSB         4
`define DACFR_D12L_CH2_LSB    20
`define DACFR_D12R_CH2_LSB    16
`define DACFR_D8_HOLD_LSB     4

// reset values
`define DACFR_LFSR_INIT       12'haaa
`define DACFR_TRI_INIT        12'h000
`define DACFR_FULL_SCALE      12'hfff
`define DACFR_MAMP_TOP        4'hb

// timing, in bus clock cycles
`define DACFR_HW_TRIG_DELAY   3

`endif

// ===== verilog/dacfr_pkg.sv
// dacfr_pkg: types shared by the converter front end.
// assumes nothing of its surroundings.
package dacfr_pkg;

  typedef enum logic [2:0] {
    DACFR_TS_TIM0 = 3'h0,
    DACFR_TS_TIM1 = 3'h1,
    DACFR_TS_TIM2 = 3'h2,
    DACFR_TS_TIM3 = 3'h3,
    DACFR_TS_TIM4 = 3'h4,
    DACFR_TS_TIM5 = 3'h5,
    DACFR_TS_EXT  = 3'h6,
    DACFR_TS_SW   = 3'h7
  } dacfr_tsel_t;

  typedef enum logic [1:0] {
    DACFR_WAVE_OFF   = 2'h0,
    DACFR_WAVE_NOISE = 2'h1,
    DACFR_WAVE_TRI   = 2'h2,
    DACFR_WAVE_RSVD  = 2'h3
  } dacfr_wave_t;

  // one channel of the control register, msb first
  typedef struct packed {
    logic        dma_request_enable;
    logic [3:0]  mask_amplitude_select;
    dacfr_wave_t waveform_select;
    dacfr_tsel_t trigger_source_select;
    logic        trigger_enable_bit;
    logic        output_buffer_off;
    logic        channel_power_on;
  } dacfr_chctl_t;

endpackage

// ===== verilog/dacfr_top.sv
// dacfr_top: digital front end of a two channel 12-bit converter with apb registers.
// assumes apb master on ref_clk; trigger inputs may be asynchronous to ref_clk.
//
// Summary of operation
// - power-on bit drives the analog macrocell and locks trigger select and mask; digital path always runs.
// - single writes: 8-bit to holding[11:4], 12-bit left [15:4], right [11:0].
// - dual 8-bit write: bits 7..0 to channel one, 15..8 to channel two.
// - dual 12-bit left write: bits 15..4 channel one, 31..20 channel two.
// - dual 12-bit right write: bits 11..0 channel one, 27..16 channel two.
// - output register is read-only; loaded only from holding plus waveform.
// - trigger disabled: output loads one cycle after the holding write.
// - trigger enabled: output loads three cycles after a timer or external trigger.
// - select 000-101 timer triggers, 110 external line nine, 111 software bit.
// - only a rising edge of timer or external line counts as trigger.
// - software trigger loads in one cycle; hardware clears the bit on that same edge.
// - trigger select cannot change while channel power-on is set.
// - dma request on timer or external trigger, never on software trigger, when enabled.
// - each channel with dma enable raises its own request.
// - wave 01 selects noise; lfsr starts at 0xaaa, steps on each triggered output load.
// - masked lfsr or triangle adds to holding data, saturating at full scale.
// - an all-zero lfsr gets a one injected so it never locks up.
// - wave select cleared resets that channel's noise and triangle state.
// - wave 10 selects triangle; counter steps on each triggered output load, adds saturating.
// - triangle counts up to the peak, down to zero, and repeats.
// - each channel has a bit switching its analog output buffer.
`timescale 1ns/100ps
`include "dacfr_consts.svh"

module dacfr_top #(
  parameter int unsigned TRIG_DELAY = `DACFR_HW_TRIG_DELAY
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`DACFR_ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // trigger sources, asynchronous
  input  wire logic [5:0]                 timer_trigger_out,
  input  wire logic                       external_line_nine,
  // dma requests, one cycle pulses
  output logic      [1:0]                 dma_req,
  // analog macrocell side
  output logic      [11:0]                output_register_ch1,
  output logic      [11:0]                output_register_ch2,
  output logic      [1:0]                 channel_power_on,
  output logic      [1:0]                 output_buffer_off
);

  localparam int unsigned NSRC = 7;

  // the pend pipe has at least one stage; long pipes only waste flops
  if (TRIG_DELAY < 1 || TRIG_DELAY > 8) begin : g_bad_delay
    $error("dacfr_top: TRIG_DELAY must be 1 to 8");
  end

  typedef struct packed {
    dacfr_pkg::dacfr_chctl_t [1:0]   ctl;
    logic [1:0]                      software_trigger_bit;
    logic [1:0][11:0]                hold;
    logic [1:0][11:0]                dout;
    logic [1:0][11:0]                lfsr;
    logic [1:0][11:0]                tri_cnt;
    logic [1:0]                      tri_down;
    logic [1:0]                      auto_pend;
    logic [1:0]                      dma_req;
    logic [1:0][TRIG_DELAY-1:0]      pend;
    logic [NSRC-1:0]                 sync1;
    logic [NSRC-1:0]                 sync2;
    logic [NSRC-1:0]                 sync3;
    logic                            pready;
    logic                            pslverr;
    logic [31:0]                     prdata;
  } dacfr_state_t;

  dacfr_state_t st;
  dacfr_state_t next_st;

  // unmasked width for noise, peak for triangle
  function automatic logic [11:0] dacfr_mask(input logic [3:0] n);
    logic [12:0] m;
    m = (13'h0002 << n) - 13'h0001;
    if (n >= `DACFR_MAMP_TOP) begin
      m = {1'b0, `DACFR_FULL_SCALE};
    end
    return m[11:0];
  endfunction

  // edge of each source; bit 7 stands for the software slot and never fires
  logic [7:0]       src_rise;
  logic [1:0]       hw_evt;
  logic [1:0]       sw_fire;
  logic [1:0]       fire;
  logic [1:0][11:0] sat_val;
  logic [1:0][11:0] lfsr_adv;
  logic [1:0][11:0] tri_adv;
  logic [1:0]       tri_dir;

  // sync1 is read by sync2 only
  assign src_rise = {1'b0, st.sync2 & ~st.sync3};

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [11:0] mask;
    logic [11:0] wave_val;
    logic [12:0] sum;
    logic [11:0] shifted;
    logic        fb;

    assign mask = dacfr_mask(st.ctl[c].mask_amplitude_select);

    // select decode: timers, external line, software bit
    assign hw_evt[c] = st.ctl[c].trigger_enable_bit
                       && st.ctl[c].trigger_source_select != dacfr_pkg::DACFR_TS_SW
                       && src_rise[st.ctl[c].trigger_source_select];
    assign sw_fire[c] = st.software_trigger_bit[c] && st.ctl[c].trigger_enable_bit
                        && st.ctl[c].trigger_source_select == dacfr_pkg::DACFR_TS_SW;
    assign fire[c] = st.pend[c][TRIG_DELAY-1] | sw_fire[c];

    always_comb begin
      case (st.ctl[c].waveform_select)
        dacfr_pkg::DACFR_WAVE_NOISE: wave_val = st.lfsr[c] & mask;
        dacfr_pkg::DACFR_WAVE_TRI:   wave_val = st.tri_cnt[c];
        default:                     wave_val = 12'h000;
      endcase
    end

    // no wrap-around: clip at full scale
    assign sum = {1'b0, st.hold[c]} + {1'b0, wave_val};
    assign sat_val[c] = sum[12] ? `DACFR_FULL_SCALE : sum[11:0];

    // polynomial x^12 + x^6 + x^4 + x + 1
    assign fb = st.lfsr[c][11] ^ st.lfsr[c][5] ^ st.lfsr[c][3] ^ st.lfsr[c][0];
    assign shifted = {st.lfsr[c][10:0], fb};
    assign lfsr_adv[c] = (shifted == 12'h000) ? 12'h001 : shifted;

    // up to the peak, down to zero, again
    always_comb begin
      tri_dir[c] = st.tri_down[c];
      tri_adv[c] = st.tri_cnt[c];
      if (!st.tri_down[c]) begin
        if (st.tri_cnt[c] >= mask) begin
          tri_dir[c] = 1'b1;
          tri_adv[c] = st.tri_cnt[c] - 12'h001;
        end else begin
          tri_adv[c] = st.tri_cnt[c] + 12'h001;
        end
      end else begin
        if (st.tri_cnt[c] == 12'h000) begin
          tri_dir[c] = 1'b0;
          tri_adv[c] = 12'h001;
        end else begin
          tri_adv[c] = st.tri_cnt[c] - 12'h001;
        end
      end
    end
  end

  logic                     acc;
  logic                     wr;
  logic                     hit;
  logic [31:0]              rd_val;
  logic [`DACFR_ADDR_W-1:0] base;
  dacfr_pkg::dacfr_chctl_t  wctl;

  always_comb begin
    next_st = st;
    hit     = 1'b0;
    rd_val  = 32'h0000_0000;
    base    = `DACFR_OFS_SINGLE_BASE;
    wctl    = st.ctl[0];
    acc     = psel & penable;
    wr      = acc & st.pready & pwrite;

    // two flops before any logic, third flop for the edge
    next_st.sync1 = {external_line_nine, timer_trigger_out};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;

    for (int c = 0; c < 2; c++) begin
      next_st.pend[c]      = (st.pend[c] << 1) | TRIG_DELAY'(hw_evt[c]);
      next_st.dma_req[c]   = hw_evt[c] & st.ctl[c].dma_request_enable;
      next_st.auto_pend[c] = 1'b0;

      // output only ever takes holding data plus wave
      if (fire[c] || (st.auto_pend[c] && !st.ctl[c].trigger_enable_bit)) begin
        next_st.dout[c] = sat_val[c];
      end
      if (fire[c]) begin
        if (st.ctl[c].waveform_select == dacfr_pkg::DACFR_WAVE_NOISE) begin
          next_st.lfsr[c] = lfsr_adv[c];
        end
        if (st.ctl[c].waveform_select == dacfr_pkg::DACFR_WAVE_TRI) begin
          next_st.tri_cnt[c]  = tri_adv[c];
          next_st.tri_down[c] = tri_dir[c];
        end
      end
      if (sw_fire[c]) begin
        next_st.software_trigger_bit[c] = 1'b0;
      end
      if (st.ctl[c].waveform_select == dacfr_pkg::DACFR_WAVE_OFF) begin
        next_st.lfsr[c]     = `DACFR_LFSR_INIT;
        next_st.tri_cnt[c]  = `DACFR_TRI_INIT;
        next_st.tri_down[c] = 1'b0;
      end
    end

    // read decode
    case (paddr)
      `DACFR_OFS_CTRL: begin
        hit    = 1'b1;
        rd_val = {3'h0, st.ctl[1], 3'h0, st.ctl[0]};
      end
      `DACFR_OFS_SOFTWARE_TRIGGER_BIT: begin
        hit    = 1'b1;
        rd_val = {30'h0000_0000, st.software_trigger_bit};
      end
      `DACFR_OFS_OUT1: begin
        hit    = 1'b1;
        rd_val = {20'h0_0000, st.dout[0]};
      end
      `DACFR_OFS_OUT2: begin
        hit    = 1'b1;
        rd_val = {20'h0_0000, st.dout[1]};
      end
      `DACFR_OFS_D12R, `DACFR_OFS_D12L, `DACFR_OFS_D8R: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    for (int c = 0; c < 2; c++) begin
      base = `DACFR_ADDR_W'(`DACFR_OFS_SINGLE_BASE + c * `DACFR_SINGLE_STRIDE);
      if (paddr == base + `DACFR_OFS_8R || paddr == base + `DACFR_OFS_12L
          || paddr == base + `DACFR_OFS_12R) begin
        hit = 1'b1;
      end
    end

    // one wait state: pready rises on the first access edge
    next_st.pready  = acc & ~st.pready;
    next_st.pslverr = acc & ~st.pready & ~hit;
    next_st.prdata  = (acc && !st.pready) ? rd_val : 32'h0000_0000;

    // writes come last so a software set beats the hardware clear
    if (wr) begin
      if (paddr == `DACFR_OFS_CTRL) begin
        for (int c = 0; c < 2; c++) begin
          wctl = dacfr_pkg::dacfr_chctl_t'(pwdata[c*`DACFR_CH_STRIDE +: `DACFR_CH_FIELD_W]);
          if (st.ctl[c].channel_power_on) begin
            wctl.trigger_source_select = st.ctl[c].trigger_source_select;
            wctl.mask_amplitude_select = st.ctl[c].mask_amplitude_select;
          end
          next_st.ctl[c] = wctl;
        end
      end
      if (paddr == `DACFR_OFS_SOFTWARE_TRIGGER_BIT) begin
        next_st.software_trigger_bit = next_st.software_trigger_bit | pwdata[1:0];
      end
      for (int c = 0; c < 2; c++) begin
        base = `DACFR_ADDR_W'(`DACFR_OFS_SINGLE_BASE + c * `DACFR_SINGLE_STRIDE);
        if (paddr == base + `DACFR_OFS_8R) begin
          next_st.hold[c]      = {pwdata[7:0], 4'h0};
          next_st.auto_pend[c] = 1'b1;
        end
        if (paddr == base + `DACFR_OFS_12L) begin
          next_st.hold[c]      = pwdata[`DACFR_12L_LSB +: 12];
          next_st.auto_pend[c] = 1'b1;
        end
        if (paddr == base + `DACFR_OFS_12R) begin
          next_st.hold[c]      = pwdata[11:0];
          next_st.auto_pend[c] = 1'b1;
        end
      end
      if (paddr == `DACFR_OFS_D8R) begin
        next_st.hold[0]   = {pwdata[7:0], 4'h0};
        next_st.hold[1]   = {pwdata[`DACFR_D8_CH2_LSB +: 8], 4'h0};
        next_st.auto_pend = 2'h3;
      end
      if (paddr == `DACFR_OFS_D12L) begin
        next_st.hold[0]   = pwdata[`DACFR_12L_LSB +: 12];
        next_st.hold[1]   = pwdata[`DACFR_D12L_CH2_LSB +: 12];
        next_st.auto_pend = 2'h3;
      end
      if (paddr == `DACFR_OFS_D12R) begin
        next_st.hold[0]   = pwdata[11:0];
        next_st.hold[1]   = pwdata[`DACFR_D12R_CH2_LSB +: 12];
        next_st.auto_pend = 2'h3;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st         <= '0;
      st.lfsr[0] <= `DACFR_LFSR_INIT;
      st.lfsr[1] <= `DACFR_LFSR_INIT;
    end else begin
      st <= next_st;
    end
  end

  // power-on leaves the datapath running; besides the macrocell it only locks trigger select and mask writes
  assign channel_power_on    = {st.ctl[1].channel_power_on, st.ctl[0].channel_power_on};
  assign output_buffer_off   = {st.ctl[1].output_buffer_off, st.ctl[0].output_buffer_off};
  assign output_register_ch1 = st.dout[0];
  assign output_register_ch2 = st.dout[1];
  assign dma_req             = st.dma_req;
  assign prdata              = st.prdata;
  assign pready              = st.pready;
  assign pslverr             = st.pslverr;

endmodule

// ===== test/dacfr_assertions.sv
// dacfr_assertions: port checker for the converter front end.
// assumes a bind into dacfr_top; tracks channel one control from apb writes.
`timescale 1ns/100ps
module dacfr_assertions (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rstn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // converter side
  input wire logic [1:0]  dma_req,
  input wire logic [11:0] output_register_ch1,
  input wire logic [1:0]  channel_power_on,
  input wire logic [1:0]  output_buffer_off
);
  logic        wr;
  logic [12:0] ctl1;
  assign wr = psel && penable && pready && pwrite;
  // shadow ignores the power-on lock: trusted only while the channel is off
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctl1 <= 13'h0000;
    end else if (wr && paddr == 8'h00) begin
      ctl1 <= pwdata[12:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ready_after_access_a: assert property ($rose(penable) && psel |=> pready)
    else $error("no ready one cycle into access");
  ready_in_access_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside access or too long");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  power_bit_a: assert property (wr && paddr == 8'h00 |=> channel_power_on == {$past(pwdata[16]), $past(pwdata[0])})
    else $error("power-on bits wrong");
  buffer_bit_a: assert property (wr && paddr == 8'h00 |=> output_buffer_off == {$past(pwdata[17]), $past(pwdata[1])})
    else $error("buffer bits wrong");
  auto_load_a: assert property (wr && paddr == 8'h10 && !ctl1[2] && ctl1[7:6] == 2'h0 |=> ##1 output_register_ch1 == $past(pwdata[11:0], 2))
    else $error("auto load late or wrong");
  trig_load_a: assert property ($changed(output_register_ch1) && ctl1[2] && ctl1[12] && ctl1[5:3] != 3'h7 |-> $past(dma_req[0], 3))
    else $error("load not three cycles after trigger");
  sw_no_dma_a: assert property (wr && paddr == 8'h04 && pwdata[0] && ctl1[5:3] == 3'h7 |=> !dma_req[0] [*3])
    else $error("dma request on software trigger");
  cover property (dma_req[0] && dma_req[1]);
  cover property (pslverr);
  cover property ($changed(output_register_ch1) && ctl1[7:6] == 2'h2);
endmodule

bind dacfr_top dacfr_assertions u_chk (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dma_req(dma_req), .output_register_ch1(output_register_ch1), .channel_power_on(channel_power_on),
  .output_buffer_off(output_buffer_off));

// ===== test/dacfr_trig_model.sv
// dacfr_trig_model: timers, external line and dma controller around the front end.
// assumes fire commands right after a rising edge of ref_clk.
`timescale 1ns/100ps
module dacfr_trig_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  // command: raise line fire_sel
  input  wire logic       fire,
  input  wire logic [2:0] fire_sel,
  // requests from the device
  input  wire logic [1:0] dma_req,
  // trigger lines and request counts
  output logic      [5:0] timer_trigger_out,
  output logic            external_line_nine,
  output int              dma_cnt0,
  output int              dma_cnt1
);
  logic [6:0] lines;
  int         hold;
  assign timer_trigger_out  = lines[5:0];
  assign external_line_nine = lines[6];
  // lines stay high a while, so a level must not retrigger
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lines    <= 7'h00;
      hold     <= 0;
      dma_cnt0 <= 0;
      dma_cnt1 <= 0;
    end else begin
      if (fire) begin
        lines <= 7'h01 << fire_sel;
        hold  <= 3 + $urandom_range(4);
      end else if (hold > 0) begin
        hold <= hold - 1;
      end else begin
        lines <= 7'h00;
      end
      dma_cnt0 <= dma_cnt0 + int'(dma_req[0]);
      dma_cnt1 <= dma_cnt1 + int'(dma_req[1]);
    end
  end
endmodule

// ===== test/tb.sv
// tb: self-checking bench for the converter front end.
// assumes dacfr_top, dacfr_trig_model and the bound checker are compiled.
`timescale 1ns/100ps
module tb;
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr, fire, ext9, err, up;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic [5:0]  tmr;
  logic [1:0]  dma_req, pwr_on, boff;
  logic [2:0]  fire_sel;
  logic [3:0]  n;
  logic [11:0] out1, out2, h, c;
  logic [23:0] hold;
  logic [7:0]  fmt [9] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28};
  int          n_errors, samples_checked, cyc, dcnt0, dcnt1, b0, t;

  dacfr_top dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_trigger_out(tmr), .external_line_nine(ext9), .dma_req(dma_req), .output_register_ch1(out1),
    .output_register_ch2(out2), .channel_power_on(pwr_on), .output_buffer_off(boff));
  dacfr_trig_model far (.ref_clk(ref_clk), .rstn(rstn), .fire(fire), .fire_sel(fire_sel), .dma_req(dma_req),
    .timer_trigger_out(tmr), .external_line_nine(ext9), .dma_cnt0(dcnt0), .dma_cnt1(dcnt1));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // idle edge first, so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dd);
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= dd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // no wait count assumed here: only the bench timeout ends a hang
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic swt();
    apb(1'b1, 8'h04, 32'h1);
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic pulse(input logic [2:0] s);
    fire_sel <= s;
    fire     <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
  endtask

  function automatic logic [12:0] cf(input logic dm, input logic [3:0] ma, input logic [1:0] wv,
                                     input logic [2:0] ts, input logic te, input logic bo, input logic on);
    return {dm, ma, wv, ts, te, bo, on};
  endfunction

  // next noise value: taps 11, 5, 3 and 0 feed bit 0
  function automatic logic [11:0] lf(input logic [11:0] x);
    return {x[10:0], x[11] ^ x[5] ^ x[3] ^ x[0]};
  endfunction

  function automatic logic [11:0] sat(input logic [11:0] a, input logic [11:0] b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[12] ? 12'hfff : s[11:0];
  endfunction

  // holding pair {ch2, ch1} after a data write
  function automatic logic [23:0] hx(input logic [7:0] a, input logic [31:0] v, input logic [23:0] o);
    case (a)
      8'h08: return {o[23:12], v[7:0], 4'h0};
      8'h0c: return {o[23:12], v[15:4]};
      8'h10: return {o[23:12], v[11:0]};
      8'h14: return {v[7:0], 4'h0, o[11:0]};
      8'h18: return {v[15:4], o[11:0]};
      8'h1c: return {v[11:0], o[11:0]};
      8'h20: return {v[27:16], v[11:0]};
      8'h24: return {v[31:20], v[15:4]};
      8'h28: return {v[15:8], 4'h0, v[7:0], 4'h0};
      default: return o;
    endcase
  endfunction

  initial begin
    {psel, penable, pwrite, fire} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire_sel = 3'h0;
    rstn = 1'b0;
    cyc = 0;
    hold = 24'h0;
    void'($urandom(32'h07edaab3));
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    foreach (fmt[i]) begin
      d = $urandom();
      apb(1'b1, fmt[i], d);
      hold = hx(fmt[i], d, hold);
      repeat (2) @(posedge ref_clk);
      chk("outputs", {8'h0, hold}, {8'h0, out2, out1});
    end
    apb(1'b1, 8'h2c, $urandom());
    apb(1'b0, 8'h2c, 32'h0);
    chk("out1 read", {20'h0, hold[11:0]}, rd);
    apb(1'b0, 8'h3c, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    $display("test formats done");
    for (int s = 0; s < 7; s++) begin
      apb(1'b1, 8'h00, {3'h0, cf(s[0], 4'h0, 2'h0, 3'(s), 1'b1, 1'b0, 1'b0), 3'h0,
                        cf(1'b1, 4'h0, 2'h0, 3'(s), 1'b1, 1'b0, 1'b0)});
      d = $urandom();
      apb(1'b1, 8'h20, d);
      repeat (2) @(posedge ref_clk);
      chk("held", {8'h0, hold}, {8'h0, out2, out1});
      b0 = dcnt0;
      pulse(3'((s + 1) % 7));
      repeat (12) @(posedge ref_clk);
      chk("other source", b0, dcnt0);
      pulse(3'(s));
      t = 0;
      while (dma_req[0] !== 1'b1 && t < 20) begin
        @(posedge ref_clk);
        t++;
      end
      chk("dma ch2", {31'h0, s[0]}, {31'h0, dma_req[1]});
      repeat (2) @(posedge ref_clk);
      chk("not yet", {8'h0, hold}, {8'h0, out2, out1});
      @(posedge ref_clk);
      hold = hx(8'h20, d, hold);
      chk("trig load", {8'h0, hold}, {8'h0, out2, out1});
      repeat (12) @(posedge ref_clk);
      chk("one request", b0 + 1, dcnt0);
    end
    $display("test triggers done");
    apb(1'b1, 8'h00, {19'h0, cf(1'b1, 4'h0, 2'h0, 3'h7, 1'b1, 1'b0, 1'b0)});
    b0 = dcnt0;
    h = 12'($urandom());
    apb(1'b1, 8'h10, {20'h0, h});
    swt();
    chk("sw load", {20'h0, h}, {20'h0, out1});
    apb(1'b0, 8'h04, 32'h0);
    chk("sw bit clear", 32'h0, rd);
    chk("no sw dma", b0, dcnt0);
    for (int i = 0; i < 6; i++) begin
      n = (i == 0) ? 4'hb : 4'($urandom_range(10));
      h = (i == 0) ? 12'hfff : 12'($urandom());
      // generator reset, then amplitude set while the channel is off
      apb(1'b1, 8'h00, {19'h0, cf(1'b0, 4'h0, 2'h0, 3'h7, 1'b1, 1'b0, 1'b0)});
      apb(1'b1, 8'h00, {19'h0, cf(1'b0, n, 2'h1, 3'h7, 1'b1, 1'b0, 1'b0)});
      apb(1'b1, 8'h10, {20'h0, h});
      swt();
      chk("noise", {20'h0, sat(h, 12'haaa & 12'((24'h2 << n) - 1))}, {20'h0, out1});
      swt();
      chk("noise step", {20'h0, sat(h, lf(12'haaa) & 12'((24'h2 << n) - 1))}, {20'h0, out1});
    end
    $display("test noise done");
    apb(1'b1, 8'h00, {19'h0, cf(1'b0, 4'h1, 2'h2, 3'h7, 1'b1, 1'b0, 1'b0)});
    apb(1'b1, 8'h10, 32'hffd);
    c = 12'h0;
    up = 1'b1;
    for (int i = 0; i < 10; i++) begin
      swt();
      chk("triangle", {20'h0, sat(12'hffd, c)}, {20'h0, out1});
      if (up && c < 12'h3) c++;
      else if (up) begin up = 1'b0; c--; end
      else if (c > 12'h0) c--;
      else begin up = 1'b1; c++; end
    end
    $display("test triangle done");
    apb(1'b1, 8'h00, {19'h0, cf(1'b0, 4'h0, 2'h0, 3'h7, 1'b1, 1'b1, 1'b1)});
    repeat (2) @(posedge ref_clk);
    chk("power buffer", 32'h5, {28'h0, pwr_on, boff});
    apb(1'b1, 8'h00, {19'h0, cf(1'b0, 4'h0, 2'h0, 3'h0, 1'b1, 1'b1, 1'b1)});
    apb(1'b0, 8'h00, 32'h0);
    chk("select locked", 32'h7, {29'h0, rd[5:3]});
    h = 12'($urandom());
    apb(1'b1, 8'h10, {20'h0, h});
    swt();
    chk("powered load", {20'h0, h}, {20'h0, out1});
    $display("test power lock done");
    summarize();
  end
endmodule
